// file: core/power_rail_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module power_rail_sequencer
   import power_seq_pkg::*;
#(
   parameter int unsigned CLK_PER_MS = CYC_PER_MS
) (
   // Clock and reset
   input  wire logic       REF_CLK_IN,
   input  wire logic       RSTN_IN,
   // Pins from outside the clock domain
   input  wire logic       PUSH_BUTTON_N_IN,
   input  wire logic       POWER_ENABLE_PIN_IN,
   input  wire logic       USB_IN,
   input  wire logic       AC_IN,
   input  wire logic       HARD_RESET_PIN_N_IN,
   input  wire logic       UNDERVOLTAGE_LOCKOUT_IN,
   input  wire logic       OVERTEMP_SHUTDOWN_IN,
   input  wire logic [6:0] RAIL_FAULT_IN,
   // Control bits
   input  wire logic       RUN_UP_SEQUENCE_BIT_IN,
   input  wire logic       RUN_DOWN_SEQUENCE_BIT_IN,
   input  wire logic       OFF_BIT_IN,
   input  wire logic [1:0] POWER_GOOD_DELAY_IN,
   input  wire logic       ENABLE_WR_IN,
   input  wire logic [6:0] ENABLE_DATA_IN,
   input  wire logic       SEQ_WR_IN,
   input  wire logic [2:0] SEQ_IDX_IN,
   input  wire logic [7:0] SEQ_DATA_IN,
   // Status
   output var  logic [6:0] RAIL_ENABLE_OUT,
   output var  logic       MAIN_POWER_GOOD_OUT,
   output var  logic       REGULATOR_POWER_GOOD_OUT,
   output var  logic       RUN_UP_SEQUENCE_BIT_OUT,
   output var  logic       SEQ_BUSY_OUT,
   output var  logic [2:0] STATE_OUT
);

   // ==========================================================
   // Declarations
   logic [17:0]        presc_reg;
   logic               tick_reg;
   logic [13:0]        sync1_reg;
   logic [13:0]        sync2_reg;
   logic [13:0]        prev_reg;
   logic [13:0]        btn_ms_reg;
   seq_state_e         state_reg;
   seq_state_e         state_next;
   seq_state_e         target_reg;
   seq_state_e         target_next;
   seq_state_e         down_target;
   logic [3:0]         step_reg;
   logic [3:0]         step_next;
   logic [TIMER_W-1:0] timer_reg;
   logic [TIMER_W-1:0] timer_next;
   logic [TIMER_W-1:0] timer_dec;
   logic [6:0]         rail_en_reg;
   logic [6:0]         rail_next;
   logic [6:0]         rail_kept;
   logic               run_up_reg;
   logic               run_up_next;
   logic [7:0]         rail_step_assign_reg [4];
   logic [7:0]         step_delay_reg_a_reg;
   logic [7:0]         step_delay_reg_b_reg;
   logic               aon_pend_reg;
   logic [3:0]         aon_ms_reg;
   logic               pg_run_reg;
   logic [8:0]         pg_ms_reg;
   logic               pg_ok_reg;
   logic               main_pg_reg;
   logic               reg_pg_reg;
   logic               busy_reg;
   logic               aon_go;
   logic               pg_go;
   logic               up_go;
   logic               down_go;
   logic               down_done;
   logic [3:0]         rail_step [NUM_RAILS];
   logic [6:0]         hit_mask;
   logic [6:0]         seq_mask;
   logic [6:0]         aon14_mask;
   logic [6:0]         aon15_mask;
   logic [6:0]         mon_ok;
   logic [6:0]         fault_hit;

   // ==========================================================
   // Millisecond tick
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         presc_reg <= '0;
         tick_reg  <= 1'b0;
      end else begin
         tick_reg  <= (presc_reg == 18'(CLK_PER_MS - 1));
         presc_reg <= (presc_reg == 18'(CLK_PER_MS - 1)) ? '0 : presc_reg + 18'h1;
      end
   end

   // ==========================================================
   // Pin synchronisers and edges
   wire [13:0] pins_async = {RAIL_FAULT_IN, OVERTEMP_SHUTDOWN_IN,
                             UNDERVOLTAGE_LOCKOUT_IN, HARD_RESET_PIN_N_IN,
                             AC_IN, USB_IN, POWER_ENABLE_PIN_IN,
                             PUSH_BUTTON_N_IN};

   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         sync1_reg <= SYNC_RST;
         sync2_reg <= SYNC_RST;
         prev_reg  <= SYNC_RST;
      end else begin
         sync1_reg <= pins_async;
         sync2_reg <= sync1_reg;
         prev_reg  <= sync2_reg;
      end
   end

   wire       pb_n       = sync2_reg[0];
   wire       power_enable_pin     = sync2_reg[1];
   wire       hrst_n     = sync2_reg[4];
   wire [6:0] rail_fault = sync2_reg[13:7];
   wire       pb_fall    = prev_reg[0] & ~pb_n;
   wire       usb_rise   = ~prev_reg[2] & sync2_reg[2];
   wire       ac_rise    = ~prev_reg[3] & sync2_reg[3];
   wire       wake_evt   = pb_fall | usb_rise | ac_rise;
   wire       fault_stop = sync2_reg[5] | sync2_reg[6];

   // Long press counter saturates so it cannot wrap into a short one
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN || pb_n) begin
         btn_ms_reg <= '0;
      end else if (tick_reg && btn_ms_reg <= 14'(BUTTON_HOLD_MS)) begin
         btn_ms_reg <= btn_ms_reg + 14'h1;
      end
   end

   wire btn_long = btn_ms_reg > 14'(BUTTON_HOLD_MS);

   // ==========================================================
   // Strobe decoding
   for (genvar i = 0; i < NUM_RAILS; i++) begin : g_rail
      localparam bit AON = AON_MASK[i];
      logic [2:0] mon_ms_reg;
      assign rail_step[i]  = rail_step_assign_reg[i/2][(i%2)*4 +: 4];
      assign hit_mask[i]   = rail_step[i] == step_reg;
      assign seq_mask[i]   = rail_step[i] != STROBE_NONE &&
                             rail_step[i] <= STROBE_LAST;
      assign aon14_mask[i] = AON && rail_step[i] == STROBE_AON_A;
      assign aon15_mask[i] = AON && rail_step[i] == STROBE_AON_B;
      // Rail gets time to ramp before it is judged
      always_ff @(posedge REF_CLK_IN) begin
         if (!RSTN_IN || !rail_en_reg[i]) begin
            mon_ms_reg <= '0;
         end else if (tick_reg && mon_ms_reg != 3'(PG_MONITOR_MS)) begin
            mon_ms_reg <= mon_ms_reg + 3'h1;
         end
      end
      assign mon_ok[i]    = mon_ms_reg == 3'(PG_MONITOR_MS);
      assign fault_hit[i] = mon_ok[i] & rail_fault[i];
   end

   wire        pg_fault = |fault_hit;
   wire [11:0] dly_all  = {step_delay_reg_b_reg[3:0], step_delay_reg_a_reg};
   wire [3:0]  dly_idx  = (state_reg == ST_DOWN) ? step_reg - 4'h2 : step_reg - 4'h1;
   wire [11:0] dly_shr  = dly_all >> {dly_idx, 1'b0};
   wire [3:0]  step_ms  = step_delay_ms(dly_shr[1:0]);
   wire [3:0]  dly6_ms  = step_delay_ms(dly_all[11:10]);
   wire        instant  = step_delay_reg_b_reg[INSTANT_BIT];
   wire        seq_busy = state_reg == ST_UP || state_reg == ST_DOWN;
   wire        en_write = ENABLE_WR_IN && !seq_busy;
   wire        timer_zero = timer_reg == '0;
   wire        aon_fire = aon_pend_reg && aon_ms_reg == 4'h0;

   assign timer_dec = (tick_reg && !timer_zero) ? timer_reg - TIMER_W'(1) : timer_reg;
   // Faulted rails drop at once, ahead of any sequencing
   assign rail_kept = ((en_write ? ENABLE_DATA_IN : rail_en_reg) |
                       (aon_fire ? aon15_mask : 7'h00)) & ~fault_hit;

   // ==========================================================
   // Sequencer
   always_comb begin
      state_next  = state_reg;
      target_next = target_reg;
      down_target = ST_OFF;
      step_next   = step_reg;
      timer_next  = timer_dec;
      rail_next   = rail_kept;
      run_up_next = run_up_reg | RUN_UP_SEQUENCE_BIT_IN;
      aon_go      = 1'b0;
      pg_go       = 1'b0;
      up_go       = 1'b0;
      down_go     = 1'b0;
      down_done   = 1'b0;
      unique case (state_reg)
         ST_OFF: begin
            if (wake_evt && !fault_stop) begin
               state_next = ST_WAIT_EN;
               timer_next = TIMER_W'(ENABLE_TIMEOUT_MS);
               aon_go     = 1'b1;
            end
         end
         ST_WAIT_EN: begin
            if (power_enable_pin && !fault_stop) begin
               up_go = 1'b1;
            end else if (timer_zero) begin
               down_go     = 1'b1;
               down_target = OFF_BIT_IN ? ST_OFF : ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (power_enable_pin && !fault_stop) begin
               up_go = 1'b1;
            end else if (wake_evt && !fault_stop) begin
               state_next = ST_WAIT_EN;
               timer_next = TIMER_W'(ENABLE_TIMEOUT_MS);
            end
         end
         ST_UP: begin
            if (timer_zero) begin
               rail_next = rail_kept | (hit_mask & seq_mask);
               if (step_reg == STROBE_LAST) begin
                  state_next  = ST_ACTIVE;
                  run_up_next = RUN_UP_SEQUENCE_BIT_IN;
                  pg_go       = 1'b1;
               end else begin
                  step_next  = step_reg + 4'h1;
                  timer_next = TIMER_W'(step_ms);
               end
            end
         end
         ST_ACTIVE: begin
            down_go = 1'b1;
            if (!hrst_n) begin
               down_target = ST_RESET;
            end else if (fault_stop || pg_fault || btn_long) begin
               down_target = ST_OFF;
            end else if (!power_enable_pin) begin
               down_target = OFF_BIT_IN ? ST_OFF : ST_SLEEP;
            end else if (RUN_DOWN_SEQUENCE_BIT_IN) begin
               down_target = ST_ACTIVE;
            end else begin
               down_go = 1'b0;
               up_go   = run_up_reg;
            end
         end
         ST_DOWN: begin
            if (!timer_zero) begin
               step_next = step_reg;
            end else if (step_reg == STROBE_AON_B) begin
               rail_next  = rail_kept & ~aon15_mask;
               step_next  = STROBE_AON_A;
               timer_next = instant ? '0 : TIMER_W'(dly6_ms);
            end else if (step_reg == STROBE_AON_A) begin
               rail_next = rail_kept & ~aon14_mask;
               down_done = 1'b1;
            end else begin
               rail_next = rail_kept & ~(seq_mask & (instant ? 7'h7F : hit_mask));
               if (instant || step_reg == STROBE_FIRST) begin
                  step_next = STROBE_AON_B;
                  timer_next = '0;
                  down_done = !OFF_BIT_IN;
               end else begin
                  step_next  = step_reg - 4'h1;
                  timer_next = TIMER_W'(step_ms);
               end
            end
         end
         ST_RESET: begin
            rail_next = 7'h00;
            if (hrst_n && timer_zero) begin
               up_go     = 1'b1;
               aon_go    = 1'b1;
               rail_next = aon14_mask;
            end
         end
         default: begin
            state_next = ST_OFF;
            rail_next  = 7'h00;
         end
      endcase
      if (aon_go) begin
         rail_next = rail_next | aon14_mask;
      end
      if (up_go) begin
         state_next = ST_UP;
         step_next  = STROBE_FIRST;
         timer_next = '0;
      end
      if (down_go) begin
         state_next  = ST_DOWN;
         step_next   = STROBE_LAST;
         timer_next  = '0;
         target_next = down_target;
      end
      if (down_done) begin
         state_next = target_reg;
         // Sleep keeps unsequenced rails; off and reset drop everything
         if (target_reg == ST_OFF || target_reg == ST_RESET) begin
            rail_next = 7'h00;
         end else begin
            rail_next = rail_next;
         end
         if (target_reg == ST_RESET) begin
            timer_next = TIMER_W'(RESET_HOLD_MS);
         end
      end
   end

   wire enter_rest = state_next != state_reg &&
                     (state_next == ST_OFF || state_next == ST_SLEEP ||
                      state_next == ST_RESET);

   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         state_reg   <= ST_OFF;
         target_reg  <= ST_OFF;
         step_reg    <= STROBE_NONE;
         timer_reg   <= '0;
         rail_en_reg <= 7'h00;
         run_up_reg  <= 1'b0;
      end else begin
         state_reg   <= state_next;
         target_reg  <= target_next;
         step_reg    <= step_next;
         timer_reg   <= timer_next;
         rail_en_reg <= rail_next;
         run_up_reg  <= run_up_next;
      end
   end

   // ==========================================================
   // Sequence registers
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN || enter_rest) begin
         rail_step_assign_reg <= ASSIGN_RST;
         step_delay_reg_a_reg <= DELAY_A_RST;
         step_delay_reg_b_reg <= DELAY_B_RST;
      end else if (SEQ_WR_IN) begin
         if (SEQ_IDX_IN <= IDX_ASSIGN_LAST) begin
            rail_step_assign_reg[SEQ_IDX_IN[1:0]] <= SEQ_DATA_IN;
         end
         if (SEQ_IDX_IN == IDX_DELAY_A) begin
            step_delay_reg_a_reg <= SEQ_DATA_IN;
         end
         if (SEQ_IDX_IN == IDX_DELAY_B) begin
            step_delay_reg_b_reg <= SEQ_DATA_IN;
         end
      end
   end

   // ==========================================================
   // Second regulator strobe timer
   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         aon_pend_reg <= 1'b0;
         aon_ms_reg   <= 4'h0;
      end else if (aon_go) begin
         aon_pend_reg <= 1'b1;
         aon_ms_reg   <= dly6_ms;
      end else if (aon_fire || state_reg == ST_RESET) begin
         aon_pend_reg <= 1'b0;
      end else if (tick_reg && aon_ms_reg != 4'h0) begin
         aon_ms_reg <= aon_ms_reg - 4'h1;
      end
   end

   // ==========================================================
   // Power good
   wire pg_clear = state_next == ST_OFF || state_next == ST_RESET ||
                   state_next == ST_UP || state_next == ST_WAIT_EN;

   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN || pg_clear) begin
         pg_run_reg <= 1'b0;
         pg_ms_reg  <= '0;
         pg_ok_reg  <= 1'b0;
      end else if (pg_go) begin
         pg_run_reg <= 1'b1;
         pg_ms_reg  <= power_good_delay_ms(POWER_GOOD_DELAY_IN);
      end else if (pg_run_reg && pg_ms_reg == '0) begin
         pg_run_reg <= 1'b0;
         pg_ok_reg  <= 1'b1;
      end else if (tick_reg && pg_ms_reg != '0) begin
         pg_ms_reg <= pg_ms_reg - 9'h1;
      end
   end

   // Judged on the live fault_hit as well as the registered enables, so a rail dropped by
   // a fault pulls its output low on the same edge it clears
   wire main_ok = |(rail_en_reg & MAIN_PG_MASK) &&
                  !(|(fault_hit & MAIN_PG_MASK));
   wire reg_ok  = |(rail_en_reg & REG_PG_MASK) &&
                  !(|(fault_hit & REG_PG_MASK));

   always_ff @(posedge REF_CLK_IN) begin
      if (!RSTN_IN) begin
         main_pg_reg <= 1'b0;
         reg_pg_reg  <= 1'b0;
         busy_reg    <= 1'b0;
      end else begin
         main_pg_reg <= state_reg == ST_ACTIVE && pg_ok_reg && main_ok;
         reg_pg_reg  <= (state_reg == ST_ACTIVE || state_reg == ST_SLEEP) &&
                        pg_ok_reg && reg_ok;
         busy_reg    <= state_next == ST_UP || state_next == ST_DOWN;
      end
   end

   // ==========================================================
   // Outputs
   assign RAIL_ENABLE_OUT          = rail_en_reg;
   assign MAIN_POWER_GOOD_OUT      = main_pg_reg;
   assign REGULATOR_POWER_GOOD_OUT = reg_pg_reg;
   assign RUN_UP_SEQUENCE_BIT_OUT  = run_up_reg;
   assign SEQ_BUSY_OUT             = busy_reg;
   assign STATE_OUT                = state_reg;

endmodule : power_rail_sequencer
`default_nettype wire

// file: core/power_seq_pkg.sv
// How it works
// - Up: fire strobes one to seven with delays
// - Step delays selectable from 1 to 10 ms
// - One strobe field per rail, shared freely
// - Four assignment and two delay registers
// - Sequence registers default on sleep, off, reset
// - Off start needs wake, enable, no fault
// - Enable is a level; 5 s timeout downs
// - From sleep, enable alone starts power-up
// - Run-up bit starts sequence, self-clears when done
// - Strobe field zero rails are never sequenced
// - Enable writes any time except while sequencing or in reset
// - Enable bits track rails, faults clear them
// - Down runs strobe seven to one, reversed
// - Instant bit drops sequenced rails without delays
// - Down triggers: bits, pins, faults, long press
// - Active to off: unsequenced rails off afterwards
// - Active to sleep: unsequenced rails keep state
// - Strobes 14 and 15 only for regulators
// - Strobe 14 on wake, 15 after delay six
// - Down fires 15 then 14 only with off
// - Main power good high only when active
// - Regulator power good high active and sleep
// - Power good low when rails off or faulted
// - Power good rises after delay from sequence end
// - Rail check starts 5 ms after enable
package power_seq_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS     = 4;
   localparam int MS_NS             = 1000000;
   localparam int CYC_PER_MS        = MS_NS / CLK_PERIOD_NS;
   localparam int ENABLE_TIMEOUT_MS = 5000;
   localparam int BUTTON_HOLD_MS    = 8000;
   localparam int RESET_HOLD_MS     = 1000;
   localparam int PG_MONITOR_MS     = 5;
   localparam int TIMER_W           = 13;

   // ==========================================================
   // Rails and strobes
   localparam int         NUM_RAILS    = 7;
   localparam logic [3:0] STROBE_NONE  = 4'h0;
   localparam logic [3:0] STROBE_FIRST = 4'h1;
   localparam logic [3:0] STROBE_LAST  = 4'h7;
   localparam logic [3:0] STROBE_AON_A = 4'hE;
   localparam logic [3:0] STROBE_AON_B = 4'hF;
   // Rail order: buck a, b, c, regulator a, b, switch a, b
   localparam logic [6:0] AON_MASK     = 7'h18;
   localparam logic [6:0] MAIN_PG_MASK = 7'h67;
   localparam logic [6:0] REG_PG_MASK  = 7'h18;

   // ==========================================================
   // Sequence register map and defaults
   localparam logic [2:0] IDX_ASSIGN_LAST = 3'h3;
   localparam logic [2:0] IDX_DELAY_A     = 3'h4;
   localparam logic [2:0] IDX_DELAY_B     = 3'h5;
   localparam int         INSTANT_BIT     = 4;
   localparam logic [7:0] ASSIGN_RST [4]  = '{8'h21, 8'hE3, 8'h4F, 8'h05};
   localparam logic [7:0] DELAY_A_RST     = 8'h00;
   localparam logic [7:0] DELAY_B_RST     = 8'h00;
   localparam logic [13:0] SYNC_RST       = 14'h0011;

   typedef enum logic [2:0] {
      ST_OFF     = 3'h0,
      ST_WAIT_EN = 3'h1,
      ST_UP      = 3'h3,
      ST_ACTIVE  = 3'h2,
      ST_DOWN    = 3'h6,
      ST_SLEEP   = 3'h7,
      ST_RESET   = 3'h4
   } seq_state_e;

   function automatic logic [3:0] step_delay_ms(input logic [1:0] code);
      unique case (code)
         2'h0: step_delay_ms = 4'h1;
         2'h1: step_delay_ms = 4'h2;
         2'h2: step_delay_ms = 4'h5;
         2'h3: step_delay_ms = 4'hA;
      endcase
   endfunction : step_delay_ms

   function automatic logic [8:0] power_good_delay_ms(input logic [1:0] code);
      unique case (code)
         2'h0: power_good_delay_ms = 9'h014;
         2'h1: power_good_delay_ms = 9'h064;
         2'h2: power_good_delay_ms = 9'h0C8;
         2'h3: power_good_delay_ms = 9'h190;
      endcase
   endfunction : power_good_delay_ms

endpackage : power_seq_pkg

// file: tb/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model (
   // Requests from the bench
   input  wire logic en_req_in,
   input  wire logic wr_req_in,
   input  wire logic busy_in,
   // Pins toward the sequencer
   output var  logic power_enable_pin_out,
   output var  logic wr_out
);
   // Enable pin is a plain level
   assign power_enable_pin_out = en_req_in;
   // Host stays off the enable bits while sequencing
   assign wr_out = wr_req_in & ~busy_in;
endmodule : host_model
`default_nettype wire

// file: tb/power_rail_sequencer_bench.sv
`timescale 1ns/100ps
`default_nettype none
module power_rail_sequencer_bench
   import power_seq_pkg::*;
;
   localparam int unsigned MS = 10;
   logic clk = 1'b0, rstn = 1'b0, pb_n = 1'b1, en_req = 1'b0, usb = 1'b0, hr_n = 1'b1;
   logic undervoltage_lockout = 1'b0, run_up = 1'b0, run_dn = 1'b0, off_bit = 1'b1, wr_req = 1'b0;
   logic seq_wr = 1'b0, power_enable_pin, wr, mpg, rpg, up_bit, busy;
   logic [6:0] fault = 7'h00, wdata = 7'h00, rails;
   logic [7:0] sdata = 8'h10;
   logic [2:0] st, sidx = 3'h5;
   int         n_errors = 0, check_count = 0, cyc;
   initial begin
      forever #2 clk = ~clk;
   end
   host_model u_host (.en_req_in(en_req), .wr_req_in(wr_req), .busy_in(busy),
      .power_enable_pin_out(power_enable_pin), .wr_out(wr));
   power_rail_sequencer #(.CLK_PER_MS(MS)) dut (
      .REF_CLK_IN(clk), .RSTN_IN(rstn), .PUSH_BUTTON_N_IN(pb_n),
      .POWER_ENABLE_PIN_IN(power_enable_pin), .USB_IN(usb), .AC_IN(1'b0),
      .HARD_RESET_PIN_N_IN(hr_n), .UNDERVOLTAGE_LOCKOUT_IN(undervoltage_lockout),
      .OVERTEMP_SHUTDOWN_IN(1'b0), .RAIL_FAULT_IN(fault),
      .RUN_UP_SEQUENCE_BIT_IN(run_up), .RUN_DOWN_SEQUENCE_BIT_IN(run_dn),
      .OFF_BIT_IN(off_bit), .POWER_GOOD_DELAY_IN(2'h0), .ENABLE_WR_IN(wr),
      .ENABLE_DATA_IN(wdata), .SEQ_WR_IN(seq_wr), .SEQ_IDX_IN(sidx),
      .SEQ_DATA_IN(sdata), .RAIL_ENABLE_OUT(rails), .MAIN_POWER_GOOD_OUT(mpg),
      .REGULATOR_POWER_GOOD_OUT(rpg), .RUN_UP_SEQUENCE_BIT_OUT(up_bit),
      .SEQ_BUSY_OUT(busy), .STATE_OUT(st));
   // ==========
   // Helpers
   task automatic give_verdict;
      if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [6:0] got, input logic [6:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle
   task automatic pulse(ref logic s);
      s = 1'b1;
      idle(1);
      s = 1'b0;
   endtask : pulse
   // Waits for a state or main power good; a later sequenced rail (0, 1, 2, 5, 6) on with an earlier one off is an error
   task automatic wt(input logic [2:0] s, input bit pg, input int lim);
      cyc = 0;
      while ((pg ? mpg !== 1'b1 : st !== s) && cyc < lim) begin
         idle(1);
         cyc++;
         if (rails[1] & !rails[0] | rails[2] & !rails[1] | rails[5] & !rails[2]
             | rails[6] & !rails[5]) chk(rails, 7'h7F);
      end
      if (cyc >= lim) begin
         n_errors++;
         give_verdict();
      end
   endtask : wt
   task automatic reup;
      pulse(run_up);
      wt(ST_UP, 0, 50);
      wt(ST_ACTIVE, 0, 500);
      wt(3'h0, 1, 400);
   endtask : reup
   // ==========
   // Scenarios
   task automatic t_up;
      chk(rails, 7'h00);
      en_req = 1'b1;
      pb_n = 1'b0;
      wt(ST_UP, 0, 100);
      pb_n = 1'b1;
      chk(7'(rails[3]), 7'h01);
      wt(ST_ACTIVE, 0, 500);
      chk(7'(cyc >= 55), 7'h01);
      chk(rails, 7'h7F);
      wt(3'h0, 1, 400);
      chk(7'(cyc >= 190), 7'h01);
      idle(3);
      chk(7'({rpg, mpg}), 7'h03);
   endtask : t_up
   task automatic t_wr;
      wdata = 7'h3F;
      pulse(wr_req);
      idle(2);
      chk(rails, 7'h3F);
      wdata = 7'h7F;
      pulse(wr_req);
      idle(2);
      chk(rails, 7'h7F);
   endtask : t_wr
   task automatic t_down(input bit fast);
      off_bit = 1'b1;
      sidx = 3'h2;
      sdata = 8'h40;
      pulse(seq_wr);
      sidx = 3'h5;
      sdata = 8'h10;
      idle(1);
      if (fast) pulse(seq_wr);
      pulse(run_dn);
      wt(ST_DOWN, 0, 50);
      wt(ST_ACTIVE, 0, 500);
      chk(7'(fast ? cyc <= 15 : cyc >= 55), 7'h01);
      chk(rails, 7'h10);
      pulse(run_up);
      idle(2);
      chk(7'(up_bit), 7'h01);
      wt(ST_ACTIVE, 0, 500);
      chk(rails, 7'h77);
      chk(7'(up_bit), 7'h00);
      wt(3'h0, 1, 400);
   endtask : t_down
   task automatic t_sleep;
      off_bit = 1'b0;
      en_req = 1'b0;
      wt(ST_SLEEP, 0, 500);
      idle(3);
      chk(rails, 7'h10);
      chk(7'({rpg, mpg}), 7'h02);
      en_req = 1'b1;
      wt(ST_ACTIVE, 0, 600);
      chk(rails, 7'h77);
      t_down(1'b0);
   endtask : t_sleep
   task automatic t_fault;
      off_bit = 1'b1;
      fault = 7'h40;
      wt(ST_OFF, 0, 600);
      fault = 7'h00;
      idle(2);
      chk(rails, 7'h00);
      chk(7'({rpg, mpg}), 7'h00);
      undervoltage_lockout = 1'b1;
      pb_n = 1'b0;
      idle(40);
      chk(7'(st), 7'(ST_OFF));
      pb_n = 1'b1;
      undervoltage_lockout = 1'b0;
      idle(5);
      usb = 1'b1;
      wt(ST_ACTIVE, 0, 600);
      chk(rails, 7'h7F);
   endtask : t_fault
   task automatic t_pins;
      hr_n = 1'b0;
      wt(ST_RESET, 0, 600);
      idle(3);
      chk(rails, 7'h00);
      hr_n = 1'b1;
      wt(ST_ACTIVE, 0, 12000);
      chk(rails & 7'h67, 7'h67);
      en_req = 1'b0;
      usb = 1'b0;
      wt(ST_OFF, 0, 600);
      usb = 1'b1;
      wt(ST_WAIT_EN, 0, 50);
      idle(3);
      chk(7'(rails[3]), 7'h01);
      idle(30);
      chk(rails, 7'h18);
      wt(ST_OFF, 0, 52000);
      chk(7'(cyc >= 49000), 7'h01);
      idle(3);
      chk(rails, 7'h00);
   endtask : t_pins
   initial begin
      idle(5);
      rstn = 1'b1;
      idle(2);
      t_up();
      t_wr();
      t_down(1'b1);
      t_sleep();
      t_fault();
      t_pins();
      give_verdict();
   end
endmodule : power_rail_sequencer_bench
bind power_rail_sequencer power_rail_sequencer_props #(.CLK_PER_MS(CLK_PER_MS)) u_props (
   .REF_CLK_IN, .RSTN_IN, .POWER_ENABLE_PIN_IN, .ENABLE_WR_IN, .ENABLE_DATA_IN,
   .RAIL_FAULT_IN, .RAIL_ENABLE_OUT, .MAIN_POWER_GOOD_OUT, .REGULATOR_POWER_GOOD_OUT,
   .RUN_UP_SEQUENCE_BIT_OUT, .SEQ_BUSY_OUT, .STATE_OUT);
`default_nettype wire

// file: tb/power_rail_sequencer_props.sv
`timescale 1ns/100ps
`default_nettype none
module power_rail_sequencer_props
   import power_seq_pkg::*;
#(
   parameter int unsigned CLK_PER_MS = 10
) (
   // Clock and reset
   input wire logic       REF_CLK_IN,
   input wire logic       RSTN_IN,
   // Watched inputs
   input wire logic       POWER_ENABLE_PIN_IN,
   input wire logic       ENABLE_WR_IN,
   input wire logic [6:0] ENABLE_DATA_IN,
   input wire logic [6:0] RAIL_FAULT_IN,
   // Watched outputs
   input wire logic [6:0] RAIL_ENABLE_OUT,
   input wire logic       MAIN_POWER_GOOD_OUT,
   input wire logic       REGULATOR_POWER_GOOD_OUT,
   input wire logic       RUN_UP_SEQUENCE_BIT_OUT,
   input wire logic       SEQ_BUSY_OUT,
   input wire logic [2:0] STATE_OUT
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RSTN_IN);
   // ==========
   // Helpers
   wire logic main_lo = STATE_OUT inside {ST_OFF, ST_SLEEP, ST_RESET, ST_WAIT_EN};
   wire logic reg_lo  = STATE_OUT inside {ST_OFF, ST_RESET};
   int        act_reg;
   // Saturates so a long active spell cannot wrap
   always_ff @(posedge REF_CLK_IN) begin
      act_reg <= (STATE_OUT != ST_ACTIVE) ? 0 : act_reg + 32'(act_reg < 100000);
   end
   // ==========
   // Properties
   a_main_pg_state: assert property (main_lo && $past(main_lo) |-> !MAIN_POWER_GOOD_OUT)
      else $error("main good high outside active");
   a_reg_pg_state: assert property (reg_lo && $past(reg_lo) |-> !REGULATOR_POWER_GOOD_OUT)
      else $error("regulator good high in off or reset");
   a_busy_state: assert property (SEQ_BUSY_OUT |->
      STATE_OUT inside {ST_UP, ST_DOWN} || $past(STATE_OUT) inside {ST_UP, ST_DOWN})
      else $error("busy outside sequencing");
   a_enable_write: assert property (ENABLE_WR_IN && STATE_OUT == ST_ACTIVE && !SEQ_BUSY_OUT
      && RAIL_FAULT_IN == 7'h00 |=> STATE_OUT != ST_ACTIVE
      || RAIL_ENABLE_OUT == $past(ENABLE_DATA_IN))
      else $error("enable write not taken");
   a_runup_clear: assert property ($fell(RUN_UP_SEQUENCE_BIT_OUT) |-> STATE_OUT != ST_UP)
      else $error("run-up bit cleared mid sequence");
   a_off_clears: assert property (STATE_OUT inside {ST_OFF, ST_RESET}
      && $past(STATE_OUT) == ST_DOWN |-> ##1 RAIL_ENABLE_OUT == 7'h00)
      else $error("rails left on after down");
   a_rails_off_pg: assert property ((RAIL_ENABLE_OUT & MAIN_PG_MASK) == 7'h00
      |=> !MAIN_POWER_GOOD_OUT)
      else $error("main good with rails off");
   a_pg_delay: assert property ($rose(MAIN_POWER_GOOD_OUT) |-> act_reg >= 19 * CLK_PER_MS)
      else $error("main good rose too early");
   a_up_needs_en: assert property (STATE_OUT == ST_UP
      && $past(STATE_OUT) inside {ST_WAIT_EN, ST_SLEEP} |-> $past(POWER_ENABLE_PIN_IN, 2))
      else $error("power-up without enable");
endmodule : power_rail_sequencer_props
`default_nettype wire
